// ===== src/rcb_consts.vh
// Constants for the RISC core bus interface block.
// Assumes inclusion by the single design file; definitions only.
`ifndef RCB_CONSTS_VH
`define RCB_CONSTS_VH

// ************************************************************
// Sizes and reset values
// ************************************************************
`define RCB_BOOT_ADDR      8'h00
`define RCB_STACK_DEPTH    16
`define RCB_REG_COUNT      4
`define RCB_MEM_WIDTH      8
`define RCB_DATA_WIDTH     8
`define RCB_OPCODE_WORD_IN_WIDTH     12
`define RCB_PROG_WIDTH     8

// ************************************************************
// Opcode fields (top four bits of the instruction word)
// ************************************************************
`define RCB_OP_MSB         11
`define RCB_OP_LSB         8
`define RCB_OP_NOP         4'h0
`define RCB_OP_LDI         4'h1
`define RCB_OP_ADD         4'h2
`define RCB_OP_LOAD        4'h3
`define RCB_OP_STORE       4'h4
`define RCB_OP_JUMP        4'h5
`define RCB_OP_CALL        4'h6
`define RCB_OP_RET         4'h7

// ************************************************************
// Probe frame layout and commands
// ************************************************************
`define RCB_PRB_BITS       16
`define RCB_PCMD_RDREG     4'h1
`define RCB_PCMD_WRREG     4'h2
`define RCB_PCMD_WRMEM     4'h3

`endif

// ===== src/rcb_core.v
// Bus interface and minimal three stage core of a scalable RISC processor.
// Assumes program memory, data memory controller, interrupt logic and a
// probe controller on the far side; fetch and data buses are synchronous to i_clk, irq and probe pins are synchronised inside.
// The probe controller leaves a few core clocks between phase select and shift clock.
//
// Functional notes
// - Instructions pass prefetch with branch, then decode, then execute.
// - Fetch bus and data bus are independent and may work in one cycle.
// - Valid, irq and ack inputs each have a polarity parameter, control outputs share POL_OUT, probe pins have none; active clock edge selectable.
// - Reset holds a known state; release starts the boot fetch.
// - Idle is high while stalled waiting for an instruction word.
// - Word valid presents a word; core latches it and pulses latched ack, except for the vector word taken during interrupt grant.
// - Program address is a word address of instruction length.
// - Sequential flag is high when the fetch address follows the last.
// - Interrupt request starts a grant cycle which word valid ends.
// - Load data is taken only in the cycle of cycle ack.
// - Store word stays stable until cycle ack returns.
// - Memory location is held with the request until cycle ack.
// - Request starts a transaction, store select marks writes, ack ends it.
// - Debug builds shift serial out data on the probe clock.
// - Phase select low means command, high means data transfer.
// - The probe reads and writes registers and writes zero to a data memory location.
// - Probe shifting follows synchronised probe clock edges, taken on the core clock.
// - Call and interrupt entry push return addresses on a hardware stack.
// - The register file allows a read and a write in one cycle.
`timescale 1ns/1ps
`include "rcb_consts.vh"

module rcb_core #(
    parameter PW         = `RCB_PROG_WIDTH,
    parameter IW         = `RCB_OPCODE_WORD_IN_WIDTH,
    parameter DW         = `RCB_DATA_WIDTH,
    parameter MW         = `RCB_MEM_WIDTH,
    parameter DEBUG      = 1,
    parameter NEG_EDGE   = 0,
    parameter POL_VALID  = 1,
    parameter POL_IRQ    = 1,
    parameter POL_ACK    = 1,
    parameter POL_OUT    = 1
) (
    // System.
    input  wire          i_clk,
    input  wire          i_rst,
    output reg           o_idle,
    // Instruction bus.
    input  wire [IW-1:0] i_opcode_word_in,
    input  wire          i_fetch_word_valid,
    input  wire          i_irq_request,
    output reg  [PW-1:0] o_program_addr_out,
    output reg           o_fetch_latched_ack,
    output reg           o_sequential_fetch,
    output reg           o_irq_grant,
    // Data bus.
    input  wire [DW-1:0] i_load_word_in,
    input  wire          i_mem_cycle_ack,
    output reg  [DW-1:0] o_store_word_out,
    output reg  [MW-1:0] o_mem_location_out,
    output reg           o_store_select,
    output reg           o_mem_cycle_request,
    // Probe port.
    input  wire          i_probe_shift_clock,
    input  wire          i_probe_serial_in,
    input  wire          i_probe_phase_select,
    output reg           o_probe_serial_out
);

    // ************************************************************
    // Local definitions
    // ************************************************************
    localparam NREG = `RCB_REG_COUNT;
    localparam SD   = `RCB_STACK_DEPTH;
    localparam PB   = `RCB_PRB_BITS;
    localparam [3:0] F_RUN = 4'h1, F_WAIT = 4'h2, F_IRQ = 4'h4, F_HALT = 4'h8;
    localparam [2:0] D_IDLE = 3'h1, D_BUSY = 3'h2, D_DONE = 3'h4;

    // Strips the configured polarity from an input or applies it to an output.
    function pol;
        input v;
        input p;
        begin
            pol = p ? v : ~v;
        end
    endfunction

    // Active edge: the core runs on an internally chosen clock edge.
    wire clk_core = NEG_EDGE ? ~i_clk : i_clk;

    // ************************************************************
    // Input qualification and probe synchronisers
    // ************************************************************
    wire valid_in = pol(i_fetch_word_valid, POL_VALID[0]);
    wire ack_in   = pol(i_mem_cycle_ack, POL_ACK[0]);
    reg  irq_s1_reg, irq_s2_reg;
    reg  [2:0] sck_s_reg, sdi_s_reg, sms_s_reg;

    // Asynchronous request and probe pins pass two flops before use.
    always @(posedge clk_core) begin
        irq_s1_reg <= pol(i_irq_request, POL_IRQ[0]);
        irq_s2_reg <= irq_s1_reg;
        sck_s_reg  <= {sck_s_reg[1:0], i_probe_shift_clock};
        sdi_s_reg  <= {sdi_s_reg[1:0], i_probe_serial_in};
        sms_s_reg  <= {sms_s_reg[1:0], i_probe_phase_select};
    end
    wire sck_rise = sck_s_reg[1] & ~sck_s_reg[2];
    wire sck_fall = ~sck_s_reg[1] & sck_s_reg[2];

    // ************************************************************
    // Storage: register file, return stack
    // ************************************************************
    reg  [DW-1:0] gpr_mem [0:NREG-1];
    reg  [PW-1:0] stk_mem [0:SD-1];
    reg  [4:0]    sp_reg;

    // ************************************************************
    // Pipeline state
    // ************************************************************
    reg  [3:0]    fst_reg;
    reg  [PW-1:0] pc_reg, last_pc_reg;
    reg  [IW-1:0] dec_ir_reg, ex_ir_reg;
    reg           dec_v_reg, ex_v_reg;
    reg  [2:0]    dst_reg;
    reg  [DW-1:0] ld_reg;
    reg  [1:0]    ld_dst_reg;
    reg           boot_reg;

    wire [3:0] ex_op = ex_ir_reg[`RCB_OP_MSB:`RCB_OP_LSB];
    wire [1:0] ex_ra = ex_ir_reg[7:6];
    wire [1:0] ex_rb = ex_ir_reg[5:4];
    wire [PW-1:0] ex_tgt = ex_ir_reg[PW-1:0];
    wire ex_mem  = ex_v_reg & ((ex_op == `RCB_OP_LOAD) | (ex_op == `RCB_OP_STORE));
    wire data_busy = (dst_reg == D_BUSY);
    wire stall   = ex_mem & ~(dst_reg == D_DONE);  // execute waits on the data bus
    wire ex_go   = ex_v_reg & ~stall;
    wire ex_br   = ex_go & ((ex_op == `RCB_OP_JUMP) | (ex_op == `RCB_OP_CALL) |
                            (ex_op == `RCB_OP_RET));
    wire [PW-1:0] ret_addr = stk_mem[sp_reg[3:0] - 4'h1];

    // Probe command decode and request into the core domain.
    reg  [PB-1:0] prb_sh_reg;
    reg  [PB-1:0] prb_cmd_reg;
    reg  [DW-1:0] prb_rd_reg;
    reg           prb_go_reg;
    wire [3:0]    prb_op  = prb_cmd_reg[15:12];
    wire [7:0]    prb_arg = prb_cmd_reg[7:0];

    // ************************************************************
    // Fetch stage with branch and interrupt handling
    // ************************************************************
    // Fetch, acknowledge and interrupt grant; branches resolved here.
    always @(posedge clk_core) begin
        if (i_rst) begin
            fst_reg             <= F_HALT;
            pc_reg              <= `RCB_BOOT_ADDR;
            last_pc_reg         <= `RCB_BOOT_ADDR;
            boot_reg            <= 1'b1;
            o_program_addr_out  <= `RCB_BOOT_ADDR;
            o_fetch_latched_ack <= pol(1'b0, POL_OUT[0]);
            o_sequential_fetch  <= pol(1'b0, POL_OUT[0]);
            o_irq_grant         <= pol(1'b0, POL_OUT[0]);
            o_idle              <= pol(1'b1, POL_OUT[0]);
            dec_v_reg           <= 1'b0;
            dec_ir_reg          <= {IW{1'b0}};
            sp_reg              <= 5'h00;
        end else begin
            o_fetch_latched_ack <= pol(1'b0, POL_OUT[0]);
            o_idle <= pol((fst_reg == F_WAIT) & ~valid_in, POL_OUT[0]);
            // A word taken by execute is consumed here, so that no instruction
            // runs twice while the next fetch is still outstanding.
            if (~stall)
                dec_v_reg <= 1'b0;
            if (ex_go & ((ex_op == `RCB_OP_CALL) | (ex_op == `RCB_OP_RET)))
                dec_v_reg <= 1'b0;
            case (fst_reg)
                F_HALT: begin
                    fst_reg <= F_RUN;  // boot fetch starts after release
                end
                F_RUN: begin
                    if (ex_br) begin
                        dec_v_reg <= 1'b0;
                    end else if (irq_s2_reg & ~boot_reg) begin
                        o_irq_grant <= pol(1'b1, POL_OUT[0]);
                        fst_reg     <= F_IRQ;
                    end else if (~stall) begin
                        o_program_addr_out <= pc_reg;
                        o_sequential_fetch <= pol(pc_reg == last_pc_reg + 1'b1,
                                                  POL_OUT[0]);
                        fst_reg <= F_WAIT;
                    end
                end
                F_WAIT: begin
                    // A word that lands while a branch resolves is on the wrong path.
                    if (valid_in) begin
                        dec_ir_reg          <= i_opcode_word_in;
                        dec_v_reg           <= ~ex_br;
                        o_fetch_latched_ack <= pol(1'b1, POL_OUT[0]);
                        last_pc_reg         <= pc_reg;
                        pc_reg              <= pc_reg + 1'b1;
                        boot_reg            <= 1'b0;
                        fst_reg             <= F_RUN;
                    end
                end
                F_IRQ: begin
                    if (valid_in) begin
                        stk_mem[sp_reg[3:0]] <= pc_reg;
                        sp_reg       <= sp_reg + 5'h01;
                        pc_reg       <= i_opcode_word_in[PW-1:0];
                        o_irq_grant  <= pol(1'b0, POL_OUT[0]);
                        fst_reg      <= F_RUN;
                    end
                end
                default: fst_reg <= F_HALT;
            endcase
            // Branch redirect from execute has priority over sequential flow.
            if (ex_br & (fst_reg != F_IRQ)) begin
                if (ex_op == `RCB_OP_CALL) begin
                    stk_mem[sp_reg[3:0]] <= pc_reg;
                    sp_reg <= sp_reg + 5'h01;
                    pc_reg <= ex_tgt;
                end else if (ex_op == `RCB_OP_RET) begin
                    sp_reg <= sp_reg - 5'h01;
                    pc_reg <= ret_addr;
                end else begin
                    pc_reg <= ex_tgt;
                end
            end
        end
    end

    // ************************************************************
    // Decode and execute stages
    // ************************************************************
    // Decode hands its word on; execute updates registers.
    always @(posedge clk_core) begin
        if (i_rst) begin
            ex_v_reg  <= 1'b0;
            ex_ir_reg <= {IW{1'b0}};
        end else if (~stall) begin
            ex_v_reg  <= dec_v_reg & ~ex_br;
            ex_ir_reg <= dec_ir_reg;
        end
    end

    // Register file: read ports for ex_ra, ex_rb and the probe, one write port.
    // Probe writes yield to execute, so they are meant for a stalled core.
    always @(posedge clk_core) begin
        if (ex_go & (ex_op == `RCB_OP_LDI))
            gpr_mem[ex_ra] <= ex_ir_reg[DW-1:0];
        else if (ex_go & (ex_op == `RCB_OP_ADD))
            gpr_mem[ex_ra] <= gpr_mem[ex_ra] + gpr_mem[ex_rb];
        else if (ex_go & (ex_op == `RCB_OP_LOAD))
            gpr_mem[ex_ra] <= ld_reg;
        else if (prb_go_reg & (prb_op == `RCB_PCMD_WRREG))
            gpr_mem[prb_cmd_reg[9:8]] <= prb_arg[DW-1:0];
    end

    // ************************************************************
    // Data bus engine
    // ************************************************************
    // Request, hold address and data until ack, then release; runs beside fetch.
    always @(posedge clk_core) begin
        if (i_rst) begin
            dst_reg             <= D_IDLE;
            o_mem_cycle_request <= pol(1'b0, POL_OUT[0]);
            o_store_select      <= pol(1'b0, POL_OUT[0]);
            o_mem_location_out  <= {MW{1'b0}};
            o_store_word_out    <= {DW{1'b0}};
            ld_reg              <= {DW{1'b0}};
            ld_dst_reg          <= 2'h0;
        end else begin
            case (dst_reg)
                D_IDLE: begin
                    if (ex_mem) begin
                        o_mem_cycle_request <= pol(1'b1, POL_OUT[0]);
                        o_store_select <= pol(ex_op == `RCB_OP_STORE, POL_OUT[0]);
                        o_mem_location_out <= gpr_mem[ex_rb][MW-1:0];
                        o_store_word_out   <= gpr_mem[ex_ra];
                        dst_reg <= D_BUSY;
                    end else if (prb_go_reg & (prb_op == `RCB_PCMD_WRMEM)) begin
                        o_mem_cycle_request <= pol(1'b1, POL_OUT[0]);
                        o_store_select      <= pol(1'b1, POL_OUT[0]);
                        // The low byte of the probe command names the location.
                        o_mem_location_out  <= prb_cmd_reg[MW-1:0];
                        o_store_word_out    <= {DW{1'b0}};
                        dst_reg <= D_BUSY;
                    end
                end
                D_BUSY: begin
                    if (ack_in) begin
                        ld_reg <= i_load_word_in;
                        o_mem_cycle_request <= pol(1'b0, POL_OUT[0]);
                        o_store_select      <= pol(1'b0, POL_OUT[0]);
                        dst_reg <= D_DONE;
                    end
                end
                // One idle cycle after each ack keeps requests two cycles apart.
                D_DONE: dst_reg <= D_IDLE;
                default: dst_reg <= D_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Probe port (debug builds only)
    // ************************************************************
    // Bits shift on synchronised probe clock edges; data phase closes a frame.
    always @(posedge clk_core) begin
        if (i_rst) begin
            prb_sh_reg         <= {PB{1'b0}};
            prb_cmd_reg        <= {PB{1'b0}};
            prb_rd_reg         <= {DW{1'b0}};
            prb_go_reg         <= 1'b0;
            o_probe_serial_out <= 1'b0;
        end else begin
            prb_go_reg <= 1'b0;
            if (DEBUG != 0) begin
                if (sck_rise)
                    prb_sh_reg <= {prb_sh_reg[PB-2:0], sdi_s_reg[1]};
                if (sck_fall)
                    o_probe_serial_out <= prb_rd_reg[DW-1];
                if (sck_fall & sms_s_reg[2])
                    prb_rd_reg <= {prb_rd_reg[DW-2:0], 1'b0};
                // Rising phase select closes the command; the data phase follows.
                // A read loads its word one cycle later, before the first data
                // phase shift clock that the controller sends.
                if (sms_s_reg[1] & ~sms_s_reg[2]) begin
                    prb_cmd_reg <= prb_sh_reg;
                    prb_go_reg  <= ~data_busy;
                end
                if (prb_go_reg & (prb_op == `RCB_PCMD_RDREG))
                    prb_rd_reg <= gpr_mem[prb_cmd_reg[9:8]];
            end
        end
    end

endmodule // rcb_core

// ===== tb/rcb_core_checker.sv
// Concurrent checks on the ports of the core's bus interface.
// Assumes default polarities (all active high) and rising-edge buses.
`timescale 1ns/1ps

module rcb_core_checker #(
    parameter PW = 8,
    parameter IW = 12,
    parameter DW = 8,
    parameter MW = 8
) (
    // Inputs watched on every port of the core.
    input wire          i_clk, i_rst, o_idle,
    input wire [IW-1:0] i_opcode_word_in,
    input wire          i_fetch_word_valid, i_irq_request,
    input wire [PW-1:0] o_program_addr_out,
    input wire          o_fetch_latched_ack, o_sequential_fetch, o_irq_grant,
    input wire [DW-1:0] i_load_word_in,
    input wire          i_mem_cycle_ack,
    input wire [DW-1:0] o_store_word_out,
    input wire [MW-1:0] o_mem_location_out,
    input wire          o_store_select, o_mem_cycle_request,
    input wire          i_probe_shift_clock, i_probe_serial_in,
    input wire          i_probe_phase_select, o_probe_serial_out
);
    // ************************************************************
    // Sequences and properties
    // ************************************************************
    // A data cycle that is still waiting for its acknowledge.
    sequence s_data_wait;
        o_mem_cycle_request && !i_mem_cycle_ack;
    endsequence
    // A data cycle completing at this edge.
    sequence s_data_done;
        o_mem_cycle_request && i_mem_cycle_ack;
    endsequence

    a_ack_has_cause: assert property (@(posedge i_clk) disable iff (i_rst)
        o_fetch_latched_ack |-> $past(i_fetch_word_valid)) else $error("ack without word");
    a_ack_one_cycle: assert property (@(posedge i_clk) disable iff (i_rst)
        o_fetch_latched_ack |=> !o_fetch_latched_ack) else $error("ack longer than a pulse");
    a_loc_held: assert property (@(posedge i_clk) disable iff (i_rst)
        s_data_wait |=> o_mem_cycle_request && $stable(o_mem_location_out)
        && $stable(o_store_select)) else $error("location or request moved");
    a_store_held: assert property (@(posedge i_clk) disable iff (i_rst)
        s_data_wait ##0 o_store_select |=> $stable(o_store_word_out))
        else $error("store word moved");
    a_req_drops: assert property (@(posedge i_clk) disable iff (i_rst)
        s_data_done |=> !o_mem_cycle_request ##1 !o_mem_cycle_request)
        else $error("request kept after ack");
    a_grant_ends: assert property (@(posedge i_clk) disable iff (i_rst)
        o_irq_grant && i_fetch_word_valid |=> !o_irq_grant) else $error("grant not ended");
    a_grant_cause: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_irq_grant) |-> $past(i_irq_request, 2) || $past(i_irq_request, 3))
        else $error("grant without request");
    a_reset_state: assert property (@(posedge i_clk) disable iff (1'b0)
        i_rst |=> o_idle && !o_mem_cycle_request && !o_irq_grant && !o_store_select
        && !o_fetch_latched_ack && o_program_addr_out == '0) else $error("bad reset state");
endmodule // rcb_core_checker

bind rcb_core rcb_core_checker #(.PW(PW), .IW(IW), .DW(DW), .MW(MW)) u_rcb_core_checker (
    .i_clk(i_clk), .i_rst(i_rst), .o_idle(o_idle), .i_opcode_word_in(i_opcode_word_in),
    .i_fetch_word_valid(i_fetch_word_valid), .i_irq_request(i_irq_request),
    .o_program_addr_out(o_program_addr_out), .o_fetch_latched_ack(o_fetch_latched_ack),
    .o_sequential_fetch(o_sequential_fetch), .o_irq_grant(o_irq_grant),
    .i_load_word_in(i_load_word_in), .i_mem_cycle_ack(i_mem_cycle_ack),
    .o_store_word_out(o_store_word_out), .o_mem_location_out(o_mem_location_out),
    .o_store_select(o_store_select), .o_mem_cycle_request(o_mem_cycle_request),
    .i_probe_shift_clock(i_probe_shift_clock), .i_probe_serial_in(i_probe_serial_in),
    .i_probe_phase_select(i_probe_phase_select), .o_probe_serial_out(o_probe_serial_out));

// ===== tb/rcb_far_side.sv
// Program memory, interrupt logic and data memory controller model.
// Assumes the core's default widths and active-high polarities.
`timescale 1ns/1ps

module rcb_far_side (
    // Clock, reset and bench controls.
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire        i_fetch_hold,
    input  wire [3:0]  i_fetch_wait,
    input  wire [3:0]  i_data_wait,
    // Core outputs.
    input  wire [7:0]  i_program_addr_out,
    input  wire        i_fetch_latched_ack,
    input  wire        i_irq_grant,
    input  wire        i_mem_cycle_request,
    // Answers to the core.
    output reg  [11:0] o_opcode_word_in,
    output reg         o_fetch_word_valid,
    output reg  [7:0]  o_load_word_in,
    output reg         o_mem_cycle_ack
);
    reg [3:0] f_cnt;
    reg [3:0] d_cnt;

    // Program image: r0 set to 0x20 at 0, a load at 2, a store at 5, otherwise no-ops.
    function automatic [11:0] rom(input [7:0] a);
        rom = (a == 8'h00) ? 12'h120 : (a == 8'h02) ? 12'h340 :
              (a == 8'h05) ? 12'h441 : 12'h000;
    endfunction

    // Word is held until latched; service address stands during grant.
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_fetch_word_valid <= 1'b0;
            f_cnt              <= 4'h0;
            o_opcode_word_in   <= 12'hfff;
        end else if (i_fetch_latched_ack || (o_fetch_word_valid && i_irq_grant)) begin
            o_fetch_word_valid <= 1'b0;
            f_cnt              <= 4'h0;
            o_opcode_word_in   <= ~o_opcode_word_in; // Released bus shows no stale word.
        end else if (!o_fetch_word_valid && !i_fetch_hold) begin
            f_cnt <= f_cnt + 4'h1;
            if (f_cnt >= i_fetch_wait) begin
                o_fetch_word_valid <= 1'b1;
                o_opcode_word_in   <= i_irq_grant ? 12'h080 : rom(i_program_addr_out);
            end
        end
    end

    // One-cycle ack after a chosen number of wait cycles, reads and writes alike.
    always @(posedge i_clk) begin
        if (i_rst || o_mem_cycle_ack || !i_mem_cycle_request) begin
            o_mem_cycle_ack <= 1'b0;
            d_cnt           <= 4'h0;
            o_load_word_in  <= 8'ha5;
        end else begin
            d_cnt <= d_cnt + 4'h1;
            if (d_cnt >= i_data_wait) begin
                o_mem_cycle_ack <= 1'b1;
                o_load_word_in  <= 8'h5a;
            end
        end
    end
endmodule // rcb_far_side

// ===== tb/rcb_core_tb.sv
// Self-checking bench for the core's fetch, interrupt, data and probe ports.
// Assumes the far-side model and checker files are compiled beforehand.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
`define WAITC(c) begin wt = 0; while (!(c) && wt < 3000) begin @(posedge i_clk); #1; \
    wt++; end if (wt >= 3000) begin n_fail++; print_verdict(); end end

module rcb_core_tb;
    reg         i_clk = 0, i_rst = 1, irq = 0, pclk = 0, psin = 0, psel = 0, fhold = 0;
    reg  [3:0]  fwait = 0, dwait = 0;
    wire [11:0] op_word;
    wire [7:0]  addr, ld_word, st_word, loc;
    wire        idle, fack, seqf, grant, fvalid, mack, wsel, req, psout;
    int         n_fail = 0, check_count = 0, wt;

    // ************************************************************
    // Design, far side and clock
    // ************************************************************
    rcb_core u_rcb_core (.i_clk(i_clk), .i_rst(i_rst), .o_idle(idle),
        .i_opcode_word_in(op_word), .i_fetch_word_valid(fvalid), .i_irq_request(irq),
        .o_program_addr_out(addr), .o_fetch_latched_ack(fack), .o_sequential_fetch(seqf),
        .o_irq_grant(grant), .i_load_word_in(ld_word), .i_mem_cycle_ack(mack),
        .o_store_word_out(st_word), .o_mem_location_out(loc), .o_store_select(wsel),
        .o_mem_cycle_request(req), .i_probe_shift_clock(pclk), .i_probe_serial_in(psin),
        .i_probe_phase_select(psel), .o_probe_serial_out(psout));
    rcb_far_side u_rcb_far_side (.i_clk(i_clk), .i_rst(i_rst), .i_fetch_hold(fhold),
        .i_fetch_wait(fwait), .i_data_wait(dwait), .i_program_addr_out(addr),
        .i_fetch_latched_ack(fack), .i_irq_grant(grant), .i_mem_cycle_request(req),
        .o_opcode_word_in(op_word), .o_fetch_word_valid(fvalid), .o_load_word_in(ld_word),
        .o_mem_cycle_ack(mack));
    initial begin
        forever #5 i_clk = ~i_clk;
    end

    // ************************************************************
    // Scenario tasks
    // ************************************************************
    // Prints the counts and the verdict, then ends the run.
    task print_verdict();
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Reset for ten cycles, checking the held state, then release.
    task do_reset();
        @(posedge i_clk) i_rst <= 1'b1;
        repeat (10) @(posedge i_clk);
        #1;
        `CHK({idle, req, grant, fack, addr}, {4'b1000, 8'h00})
        @(posedge i_clk) i_rst <= 1'b0;
    endtask

    // Boot fetches run 0,1,2.. with one ack per word; a held fetch shows idle.
    task fetch_boot(input [3:0] w);
        fwait <= w;
        do_reset();
        for (int i = 0; i < 6; i++) begin
            `WAITC(fack)
            `CHK(addr, i[7:0])
            `CHK(seqf, i != 0)
            `WAITC(!fack)
        end
        @(posedge i_clk) fhold <= 1'b1;
        repeat (12) @(posedge i_clk);
        #1;
        `CHK(idle, 1'b1)
        @(posedge i_clk) fhold <= 1'b0;
    endtask

    // The load then the store reach the data bus, with the given wait states.
    task data_bus(input [3:0] w);
        dwait <= w;
        fwait <= 4'h1;
        do_reset();
        `WAITC(req)
        `CHK(wsel, 1'b0)
        `WAITC(!req)
        `WAITC(req)
        `CHK(wsel, 1'b1)
        `CHK({loc, st_word}, {8'h20, 8'h5a})
        `WAITC(!req)
    endtask

    // Interrupt raises grant, service address is fetched, then the next fetch is at 0x80 and not sequential.
    task irq_entry();
        repeat (20) @(posedge i_clk);
        irq <= 1'b1;
        `WAITC(grant)
        irq <= 1'b0; // Interrupt logic withdraws its request once granted.
        `WAITC(!grant)
        `WAITC(addr == 8'h80)
        `CHK(addr, 8'h80)
        `CHK(seqf, 1'b0)
    endtask

    // One probe bit: clock low then high, 80 ns in all; q is taken before the fall.
    task prb_bit(input b, output q);
        @(posedge i_clk) begin
            psin <= b;
            pclk <= 1'b0;
        end
        repeat (4) @(posedge i_clk);
        pclk <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1 q = psout;
    endtask

    // Command phase with select low, then a data phase of eight clocks.
    task prb_frame(input [15:0] cmd, output [7:0] rd);
        reg q;
        psel <= 1'b0;
        for (int i = 15; i >= 0; i--) prb_bit(cmd[i], q);
        @(posedge i_clk) psel <= 1'b1;
        repeat (4) @(posedge i_clk); // Core loads read data before shifting.
        for (int i = 7; i >= 0; i--) begin
            prb_bit(1'b0, q);
            rd[i] = q;
        end
        @(posedge i_clk) psel <= 1'b0;
        pclk <= 1'b0;
        repeat (8) @(posedge i_clk);
    endtask

    // Write a register, read it back, then write zero to memory through the probe.
    task probe_access();
        reg [7:0] rd;
        fhold <= 1'b1;
        repeat (30) @(posedge i_clk);
        prb_frame({4'h2, 2'b00, 2'b10, 8'hc3}, rd);
        prb_frame({4'h1, 2'b00, 2'b10, 8'h00}, rd);
        `CHK(rd, 8'hc3)
        fork
            prb_frame({4'h3, 2'b00, 2'b00, 8'h4c}, rd);
            begin
                `WAITC(req)
                `CHK({wsel, loc, st_word}, {1'b1, 8'h4c, 8'h00})
            end
        join
        fhold <= 1'b0;
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        fetch_boot(4'h0);
        fetch_boot(4'h3);
        data_bus(4'h0);
        data_bus(4'h5);
        irq_entry();
        probe_access();
        print_verdict();
    end
endmodule // rcb_core_tb
